//--- verif/spi_echo_peer.sv
`timescale 1ns/1ps
// -------------------------------------------------
// Echo peer: hands every shifted word straight back
// -------------------------------------------------
module spi_echo_peer (
   input wire logic sys_clk_i, // Bus clock
   input wire logic rst_i, // Async reset
   input wire logic run_i, // Peer active
   input wire logic tx_valid_i, // Head valid
   input wire logic [31:0] tx_data_i, // Head word
   input wire logic rx_ready_i, // Room in receive
   output logic tx_pop_o, // Take head
   output logic rx_push_o, // Word returned
   output logic [31:0] rx_data_o // Returned word
);
   // Pop every other cycle; receive room for the next pop is sampled before the word being returned is counted;
   // data toggles between words so a stale value never looks valid
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_pop_o <= 1'b0;
         rx_push_o <= 1'b0;
         rx_data_o <= 32'h0000_0000;
      end else begin
         tx_pop_o <= run_i && tx_valid_i && rx_ready_i && !tx_pop_o;
         rx_push_o <= tx_pop_o;
         rx_data_o <= tx_pop_o ? tx_data_i : ~rx_data_o;
      end
   end
endmodule // spi_echo_peer

//--- verif/spi_fifo_regs_checker.sv
`timescale 1ns/1ps
// ---------------------------------
// Port checker for the register slice
// ---------------------------------
module spi_fifo_regs_checker
   import spi_regs_pkg::*;
(
   input wire logic sys_clk_i, // Bus clock
   input wire logic rst_i, // Async reset
   input wire logic [ADDR_W-1:0] reg_addr_i, // Offset
   input wire logic reg_rd_i, // Read strobe
   input wire logic [REG_W-1:0] reg_rdata_o, // Read data
   input wire logic module_enable_i, // Unit enable
   input wire logic tx_valid_o, // Head valid
   input wire logic rx_ready_o, // Receive room
   input wire logic tx_empty_flag_o, // Tx empty
   input wire logic rx_full_flag_o, // Rx full
   input wire logic serial_clk_o // Serial clock
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // Read data only in the cycle after a read
   rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
      else $error("read data outside read slot");
   stat_pad_a: assert property (reg_rd_i && reg_addr_i == OFS_LEVEL |=>
      reg_rdata_o[15:14] == 2'b00 && reg_rdata_o[7:6] == 2'b00) else $error("status pad");
   cnt_width_a: assert property (reg_rd_i && reg_addr_i == OFS_LEVEL |=>
      reg_rdata_o[13:12] == 2'b00 && reg_rdata_o[5:4] == 2'b00) else $error("count width");
   cnt_bound_a: assert property (reg_rd_i && reg_addr_i == OFS_LEVEL |=>
      reg_rdata_o[11:8] <= 4'h8 && reg_rdata_o[3:0] <= 4'h8) else $error("count above depth");
   baud_pad_a: assert property (reg_rd_i && reg_addr_i == OFS_BAUD |=>
      reg_rdata_o[15:13] == 3'b000) else $error("divisor pad");
   ev_pad_a: assert property (reg_rd_i && reg_addr_i == OFS_EVENT_EN |=>
      (reg_rdata_o & ~EV_IMPL_MASK) == 16'h0000) else $error("enable pad");
   tx_empty_a: assert property (tx_empty_flag_o == !tx_valid_o)
      else $error("tx empty flag");
   rx_full_a: assert property (rx_full_flag_o == !rx_ready_o)
      else $error("rx full flag");
   sclk_off_a: assert property (!module_enable_i [*2] |-> !serial_clk_o)
      else $error("serial clock while disabled");
endmodule // spi_fifo_regs_checker

bind spi_fifo_regs spi_fifo_regs_checker u_chk (.sys_clk_i, .rst_i, .reg_addr_i, .reg_rd_i,
   .reg_rdata_o, .module_enable_i, .tx_valid_o, .rx_ready_o, .tx_empty_flag_o,
   .rx_full_flag_o, .serial_clk_o);

//--- verif/spi_fifo_regs_tb.sv
`timescale 1ns/1ps
// ---------------------------------
// Bench: register slice with an echo peer
// ---------------------------------
module spi_fifo_regs_tb;
   import spi_regs_pkg::*;
   logic sys_clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, run = 1'b0;
   logic module_enable_i = 1'b0, tx_valid_o, tx_pop_i, rx_push_i, rx_ready_o, irq_o;
   logic tx_empty_flag_o, tx_full_flag_o, rx_empty_flag_o, rx_full_flag_o, serial_clk_o;
   logic [2:0] reg_addr_i = 3'h0;
   logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o;
   logic [4:0] fine_word_size_i = 5'h07, fl = 5'h00;
   logic [31:0] tx_data_o, rx_data_i;
   int n_errors = 0, checks = 0;
   spi_fifo_regs DUT (.sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
      .reg_rdata_o, .module_enable_i, .fine_word_size_i, .word_mode_i(2'b00),
      .frame_error_flag_i(fl[4]), .activity_flag_i(fl[3]), .underrun_flag_i(fl[2]),
      .shifter_empty_flag_i(fl[1]), .overflow_flag_i(fl[0]), .tx_data_o, .tx_valid_o,
      .tx_pop_i, .rx_data_i, .rx_push_i, .rx_ready_o, .tx_empty_flag_o, .tx_full_flag_o,
      .rx_empty_flag_o, .rx_full_flag_o, .serial_clk_o, .irq_o);
   spi_echo_peer peer (.sys_clk_i, .rst_i, .run_i(run), .tx_valid_i(tx_valid_o),
      .tx_data_i(tx_data_o), .rx_ready_i(rx_ready_o), .tx_pop_o(tx_pop_i),
      .rx_push_o(rx_push_i), .rx_data_o(rx_data_i));
   // 200 MHz bus clock
   initial begin
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task end_sim;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // One-cycle bus strobes, changed right after the edge
   task wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
      #1;
   endtask
   task rd(input logic [2:0] a, input logic [15:0] e);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      #1 chk(32'(reg_rdata_o), 32'(e));
   endtask
   // Bounded wait; running out ends the run
   task automatic wait_flag(ref logic f, input int lim);
      int k;
      for (k = 0; k < lim && f !== 1'b1; k++) @(posedge sys_clk_i) #1;
      if (f !== 1'b1) begin
         n_errors++;
         $display("wrong value at %0t: wait ran out", $time);
         end_sim;
      end
   endtask
   task t_regs;
      rd(OFS_BAUD, 16'h0000);
      rd(OFS_EVENT_EN, 16'h0000);
      wr(OFS_BAUD, 16'hffff);
      rd(OFS_BAUD, 16'h1fff);
      wr(OFS_EVENT_EN, 16'hffff);
      rd(OFS_EVENT_EN, 16'h19eb);
      wr(OFS_LEVEL, 16'hffff);
      rd(OFS_LEVEL, 16'h0000);
      rd(3'h6, 16'h0000);
   endtask
   task t_baud;
      wr(OFS_BAUD, 16'h0002);
      module_enable_i <= 1'b1;
      wait_flag(serial_clk_o, 20);
      for (int k = 1; k < 7; k++) begin
         @(posedge sys_clk_i);
         #1 chk(32'(serial_clk_o), 32'(k % 6 < 3));
      end
      module_enable_i <= 1'b0;
   endtask
   // One size code per lane, plus code zero, through the window, out to the peer and back
   task t_lanes;
      logic [4:0] sz[5] = '{5'h1f, 5'h17, 5'h0f, 5'h07, 5'h00};
      logic [31:0] ex[5] = '{32'hbeef1234, 32'hef1234, 32'h1234, 32'h34, 32'h34};
      for (int i = 0; i < 5; i++) begin
         fine_word_size_i <= sz[i];
         wr(OFS_DATA_HI, 16'hbeef);
         wr(OFS_DATA_LO, 16'h1234);
         chk(tx_data_o, ex[i]);
         run <= 1'b1;
         wait_flag(tx_empty_flag_o, 20);
         run <= 1'b0;
         rd(OFS_DATA_LO, ex[i][15:0]);
         rd(OFS_DATA_HI, ex[i][31:16]);
      end
   endtask
   // Fill past depth, loop back, drain
   task t_fill;
      wr(OFS_EVENT_EN, 16'h0002);
      for (int i = 0; i < 9; i++) wr(OFS_DATA_LO, {8'hc3, 8'(i)});
      repeat (2) @(posedge sys_clk_i);
      #1 chk(32'(irq_o), 32'h1);
      chk(32'(tx_full_flag_o), 32'h1);
      rd(OFS_LEVEL, 16'h0008);
      wr(OFS_EVENT_EN, 16'h0001);
      run <= 1'b1;
      wait_flag(rx_full_flag_o, 60);
      run <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      #1 chk(32'(irq_o), 32'h1);
      rd(OFS_LEVEL, 16'h0800);
      for (int i = 0; i < 8; i++) rd(OFS_DATA_LO, {8'h00, 8'(i)});
      rd(OFS_LEVEL, 16'h0000);
      chk(32'(rx_empty_flag_o), 32'h1);
   endtask
   // Each enable but bits 1 and 0 alone; status flags go off then on, queue empty flags stay on
   task t_irq;
      int b[7] = '{12, 11, 8, 7, 6, 5, 3};
      logic [4:0] oh;
      for (int i = 0; i < 7; i++) begin
         oh = (i < 5) ? (5'h10 >> i) : 5'h00;
         wr(OFS_EVENT_EN, 16'h0001 << b[i]);
         fl <= ~oh;
         repeat (3) @(posedge sys_clk_i);
         #1 chk(32'(irq_o), (i < 5) ? 32'h0 : 32'h1);
         fl <= oh;
         repeat (3) @(posedge sys_clk_i);
         #1 chk(32'(irq_o), 32'h1);
      end
      wr(OFS_EVENT_EN, 16'h0000);
      repeat (3) @(posedge sys_clk_i);
      #1 chk(32'(irq_o), 32'h0);
   endtask
   initial begin
      repeat (16) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      t_regs;
      t_baud;
      t_lanes;
      t_fill;
      t_irq;
      end_sim;
   end
endmodule // spi_fifo_regs_tb

//--- verilog/baud_gen.sv
`timescale 1ns/1ps
// Serial clock divider from the bus clock
module baud_gen (
   input wire logic sys_clk_i, // Bus clock
   input wire logic rst_i, // Async reset, active high
   input wire logic enable_i, // Module enable
   input wire logic [spi_regs_pkg::BAUD_W-1:0] divisor_i, // Divisor value
   output logic serial_clk_o // Divided clock
);
   import spi_regs_pkg::*;

   logic [BAUD_W-1:0] half_cnt_r;

   // Half period is divisor plus one cycles, full period twice that
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         half_cnt_r <= '0;
         serial_clk_o <= 1'b0;
      end else if (!enable_i) begin
         half_cnt_r <= '0;
         serial_clk_o <= 1'b0;
      end else if (half_cnt_r >= divisor_i) begin
         half_cnt_r <= '0;
         serial_clk_o <= ~serial_clk_o;
      end else begin
         half_cnt_r <= half_cnt_r + 1'b1;
      end
   end
endmodule // baud_gen

//--- verilog/queue_mem.sv
`timescale 1ns/1ps
// Small two-port store for one queue, read data from a register
module queue_mem (
   input wire logic sys_clk_i, // Bus clock
   input wire logic rst_i, // Async reset, active high
   input wire logic wr_en_i, // Write strobe
   input wire logic [spi_regs_pkg::PTR_W-1:0] wr_addr_i, // Write slot
   input wire logic [spi_regs_pkg::DATA_W-1:0] wr_data_i, // Write word
   input wire logic [spi_regs_pkg::PTR_W-1:0] rd_addr_i, // Slot read next
   output logic [spi_regs_pkg::DATA_W-1:0] rd_data_o // Registered word
);
   import spi_regs_pkg::*;

   logic [DATA_W-1:0] mem_r [QUEUE_DEPTH];

   // Storage array, no reset needed
   always_ff @(posedge sys_clk_i) begin
      if (wr_en_i) begin
         mem_r[wr_addr_i] <= wr_data_i;
      end
   end

   // Bypass keeps the head word current when writing into an empty queue
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_data_o <= '0;
      end else if (wr_en_i && (wr_addr_i == rd_addr_i)) begin
         rd_data_o <= wr_data_i;
      end else begin
         rd_data_o <= mem_r[rd_addr_i];
      end
   end
endmodule // queue_mem

//--- verilog/spi_fifo_regs.sv
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps
// Register slice: queue levels, data window, divisor and event enables
module spi_fifo_regs (
   input wire logic sys_clk_i, // Bus clock, 200 MHz
   input wire logic rst_i, // Async reset, active high
   // Register port
   input wire logic [spi_regs_pkg::ADDR_W-1:0] reg_addr_i, // Register offset
   input wire logic [spi_regs_pkg::REG_W-1:0] reg_wdata_i, // Write data
   input wire logic reg_wr_i, // Write strobe
   input wire logic reg_rd_i, // Read strobe
   output logic [spi_regs_pkg::REG_W-1:0] reg_rdata_o, // Read data, next cycle
   // Control from the rest of the unit
   input wire logic module_enable_i, // Unit enabled
   input wire logic [4:0] fine_word_size_i, // Word size code
   input wire logic [1:0] word_mode_i, // Coarse size when code is zero
   // Status flags kept elsewhere
   input wire logic frame_error_flag_i, // Frame error seen
   input wire logic activity_flag_i, // Transfer in progress
   input wire logic underrun_flag_i, // Transmit underrun
   input wire logic shifter_empty_flag_i, // Nothing left to shift
   input wire logic overflow_flag_i, // Receive overflow
   // Shifter side
   output logic [spi_regs_pkg::DATA_W-1:0] tx_data_o, // Transmit head word
   output logic tx_valid_o, // Transmit head valid
   input wire logic tx_pop_i, // Shifter took head
   input wire logic [spi_regs_pkg::DATA_W-1:0] rx_data_i, // Received word
   input wire logic rx_push_i, // Received word strobe
   output logic rx_ready_o, // Receive queue has room
   // Derived flags and outputs
   output logic tx_empty_flag_o, // Transmit queue empty
   output logic tx_full_flag_o, // Transmit queue full
   output logic rx_empty_flag_o, // Receive queue empty
   output logic rx_full_flag_o, // Receive queue full
   output logic serial_clk_o, // Divided serial clock
   output logic irq_o // Interrupt request
);
   import spi_regs_pkg::*;

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   logic [CNT_W-1:0] tx_entry_count_r;
   logic [CNT_W-1:0] tx_entry_count_nxt;
   logic [CNT_W-1:0] rx_entry_count_r;
   logic [CNT_W-1:0] rx_entry_count_nxt;
   logic [PTR_W-1:0] tx_wr_ptr_r;
   logic [PTR_W-1:0] tx_rd_ptr_r;
   logic [PTR_W-1:0] tx_rd_ptr_nxt;
   logic [PTR_W-1:0] rx_wr_ptr_r;
   logic [PTR_W-1:0] rx_rd_ptr_r;
   logic [PTR_W-1:0] rx_rd_ptr_nxt;
   logic [HALF_W-1:0] tx_high_r;
   logic [HALF_W-1:0] rx_high_r;
   logic [BAUD_W-1:0] baud_divisor_value_r;
   logic [REG_W-1:0] event_enable_r;
   logic [DATA_W-1:0] rx_head;
   logic [DATA_W-1:0] rx_head_masked;
   logic [DATA_W-1:0] tx_word;
   logic [DATA_W-1:0] cur_mask;
   logic [REG_W-1:0] level_word;
   logic [REG_W-1:0] event_vec;
   logic [CNT_W-1:0] cnt_bits;
   logic wr_data_lo;
   logic wr_data_hi;
   logic wr_baud;
   logic wr_event_en;
   logic rd_data_lo;
   logic tx_push;
   logic tx_take;
   logic rx_store;
   logic rx_take;
   logic irq_r;

   // -----------------------------------------------------------------
   // Address decode
   // -----------------------------------------------------------------

   // One strobe per register; writes to read-only offsets fall away
   assign wr_data_lo = reg_wr_i && (reg_addr_i == OFS_DATA_LO);
   assign wr_data_hi = reg_wr_i && (reg_addr_i == OFS_DATA_HI);
   assign wr_baud = reg_wr_i && (reg_addr_i == OFS_BAUD);
   assign wr_event_en = reg_wr_i && (reg_addr_i == OFS_EVENT_EN);
   assign rd_data_lo = reg_rd_i && (reg_addr_i == OFS_DATA_LO);

   // Lane selection tracks the live word size inputs
   assign cur_mask = lane_mask(lane_of(fine_word_size_i, word_mode_i));
   assign cnt_bits = count_mask(QUEUE_DEPTH);

   // -----------------------------------------------------------------
   // Transmit queue
   // -----------------------------------------------------------------

   // Low half write completes the word; a full queue drops it silently
   assign tx_push = wr_data_lo && (tx_entry_count_r != CNT_FULL);
   assign tx_take = tx_pop_i && (tx_entry_count_r != CNT_ZERO);

   // Unused lanes are stored as zero so the shifter never sees stale bits
   assign tx_word = {tx_high_r, reg_wdata_i} & cur_mask;

   // Upper half is staged until the low half write arrives
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_high_r <= REG_RESET;
      end else if (wr_data_hi) begin
         tx_high_r <= reg_wdata_i;
      end
   end

   // Read pointer steps when the shifter takes the head
   assign tx_rd_ptr_nxt = tx_take ? PTR_W'(tx_rd_ptr_r + 1'b1) : tx_rd_ptr_r;

   // Pointers wrap naturally because the depth is a power of two
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_wr_ptr_r <= '0;
         tx_rd_ptr_r <= '0;
      end else begin
         tx_rd_ptr_r <= tx_rd_ptr_nxt;
         if (tx_push) begin
            tx_wr_ptr_r <= PTR_W'(tx_wr_ptr_r + 1'b1);
         end
      end
   end

   // Push and pop in one cycle leave the count alone
   always_comb begin
      tx_entry_count_nxt = tx_entry_count_r;
      if (tx_push && !tx_take) begin
         tx_entry_count_nxt = tx_entry_count_r + 1'b1;
      end else if (tx_take && !tx_push) begin
         tx_entry_count_nxt = tx_entry_count_r - 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_entry_count_r <= CNT_ZERO;
      end else begin
         tx_entry_count_r <= tx_entry_count_nxt;
      end
   end

   // Head word is read one slot ahead so it stands ready each cycle
   queue_mem u_tx_mem (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .wr_en_i(tx_push),
      .wr_addr_i(tx_wr_ptr_r),
      .wr_data_i(tx_word),
      .rd_addr_i(tx_rd_ptr_nxt),
      .rd_data_o(tx_data_o)
   );

   assign tx_valid_o = (tx_entry_count_r != CNT_ZERO);

   // -----------------------------------------------------------------
   // Receive queue
   // -----------------------------------------------------------------

   // A word arriving on a full queue is lost; overflow is flagged outside
   assign rx_store = rx_push_i && (rx_entry_count_r != CNT_FULL);
   assign rx_take = rd_data_lo && (rx_entry_count_r != CNT_ZERO);
   assign rx_ready_o = (rx_entry_count_r != CNT_FULL);

   assign rx_rd_ptr_nxt = rx_take ? PTR_W'(rx_rd_ptr_r + 1'b1) : rx_rd_ptr_r;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_wr_ptr_r <= '0;
         rx_rd_ptr_r <= '0;
      end else begin
         rx_rd_ptr_r <= rx_rd_ptr_nxt;
         if (rx_store) begin
            rx_wr_ptr_r <= PTR_W'(rx_wr_ptr_r + 1'b1);
         end
      end
   end

   always_comb begin
      rx_entry_count_nxt = rx_entry_count_r;
      if (rx_store && !rx_take) begin
         rx_entry_count_nxt = rx_entry_count_r + 1'b1;
      end else if (rx_take && !rx_store) begin
         rx_entry_count_nxt = rx_entry_count_r - 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_entry_count_r <= CNT_ZERO;
      end else begin
         rx_entry_count_r <= rx_entry_count_nxt;
      end
   end

   queue_mem u_rx_mem (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .wr_en_i(rx_store),
      .wr_addr_i(rx_wr_ptr_r),
      .wr_data_i(rx_data_i),
      .rd_addr_i(rx_rd_ptr_nxt),
      .rd_data_o(rx_head)
   );

   // Only the lanes of the current size reach software
   assign rx_head_masked = rx_head & cur_mask;

   // Upper half is caught when the low half pops, read later
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_high_r <= REG_RESET;
      end else if (rx_take) begin
         rx_high_r <= rx_head_masked[DATA_W-1:HALF_W];
      end
   end

   // -----------------------------------------------------------------
   // Queue flags
   // -----------------------------------------------------------------

   // Flags follow the next count so they line up with the count register
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_empty_flag_o <= 1'b1;
         tx_full_flag_o <= 1'b0;
      end else begin
         tx_empty_flag_o <= (tx_entry_count_nxt == CNT_ZERO);
         tx_full_flag_o <= (tx_entry_count_nxt == CNT_FULL);
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_empty_flag_o <= 1'b1;
         rx_full_flag_o <= 1'b0;
      end else begin
         rx_empty_flag_o <= (rx_entry_count_nxt == CNT_ZERO);
         rx_full_flag_o <= (rx_entry_count_nxt == CNT_FULL);
      end
   end

   // -----------------------------------------------------------------
   // Software registers
   // -----------------------------------------------------------------

   // Divisor; no shadow copy, so a change while enabled glitches the clock
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         baud_divisor_value_r <= '0;
      end else if (wr_baud) begin
         baud_divisor_value_r <= reg_wdata_i[BAUD_W-1:0];
      end
   end

   // Only the implemented enable bits are kept
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         event_enable_r <= REG_RESET;
      end else if (wr_event_en) begin
         event_enable_r <= reg_wdata_i & EV_IMPL_MASK;
      end
   end

   // -----------------------------------------------------------------
   // Read path
   // -----------------------------------------------------------------

   // Unused status bits stay zero by construction
   always_comb begin
      level_word = REG_RESET;
      level_word[RX_CNT_LSB +: CNT_W] = rx_entry_count_r & cnt_bits;
      level_word[TX_CNT_LSB +: CNT_W] = tx_entry_count_r & cnt_bits;
   end

   // Unmapped offsets read zero; data stands only the cycle after the strobe
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         reg_rdata_o <= REG_RESET;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            OFS_LEVEL: reg_rdata_o <= level_word;
            OFS_DATA_LO: reg_rdata_o <= rx_head_masked[HALF_W-1:0];
            OFS_DATA_HI: reg_rdata_o <= rx_high_r;
            OFS_BAUD: reg_rdata_o <= {{(REG_W-BAUD_W){1'b0}}, baud_divisor_value_r};
            OFS_EVENT_EN: reg_rdata_o <= event_enable_r;
            default: reg_rdata_o <= REG_RESET;
         endcase
      end else begin
         reg_rdata_o <= REG_RESET;
      end
   end

   // -----------------------------------------------------------------
   // Interrupt events
   // -----------------------------------------------------------------

   // Condition vector laid out like the enable register
   always_comb begin
      event_vec = REG_RESET;
      event_vec[EV_FRAME_ERR] = frame_error_flag_i;
      event_vec[EV_ACTIVITY] = activity_flag_i;
      event_vec[EV_UNDERRUN] = underrun_flag_i;
      event_vec[EV_SHIFT_EMPTY] = shifter_empty_flag_i;
      event_vec[EV_OVERFLOW] = overflow_flag_i;
      event_vec[EV_RX_EMPTY] = rx_empty_flag_o;
      event_vec[EV_TX_EMPTY] = tx_empty_flag_o;
      event_vec[EV_TX_FULL] = tx_full_flag_o;
      event_vec[EV_RX_FULL] = rx_full_flag_o;
   end

   // Level request, registered to keep the output glitch free
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(event_vec & event_enable_r);
      end
   end

   assign irq_o = irq_r;

   // -----------------------------------------------------------------
   // Serial clock
   // -----------------------------------------------------------------

   // Divider reads the live divisor; software keeps it steady while enabled
   baud_gen u_baud (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .enable_i(module_enable_i),
      .divisor_i(baud_divisor_value_r),
      .serial_clk_o(serial_clk_o)
   );

endmodule // spi_fifo_regs

//--- verilog/spi_regs_pkg.sv
// Overview of operation
// - Status bits 13..8 report live receive queue entry count
// - Status bits 5..0 report live transmit queue entry count
// - Count bit 3 exists only when queue depth is at least 8
// - Count bit 4 exists only when queue depth is at least 16
// - Count bit 5 exists only when queue depth equals 32
// - Status bits 15..14 and 7..6 always read zero
// - Word sizes 9..16 use only low 16 data window bits
// - Word sizes 2..8 use only low 8 data window bits
// - Word sizes 25..32 use all of bits 31..16 plus low half
// - Word sizes 17..24 use bits 23..16 plus low half
// - Divisor register holds 13 bits, resets zero, bits 15..13 read zero
// - Enable bit 12 lets frame errors raise an event
// - Enable bit 11 lets the activity flag raise an event
// - Enable bit 8 lets transmit underrun raise an event
// - Enable bit 7 lets shifter empty raise events
// - Enable bit 6 lets receive overflow raise an event
// - Enable bit 5 lets receive empty raise events
// - Enable bit 3 lets transmit empty raise events
// - Enable bit 1 lets transmit full raise events
// - Enable bit 0 lets receive full raise events
// - Transmit side is empty exactly when its entry count is zero
// - Data window writes load transmit queue, reads return received data
// - Serial clock is bus clock over twice the sum of divisor and one
package spi_regs_pkg;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam int unsigned ADDR_W = 3;
   localparam int unsigned REG_W = 16;
   localparam logic [ADDR_W-1:0] OFS_LEVEL = 3'h0;
   localparam logic [ADDR_W-1:0] OFS_DATA_LO = 3'h1;
   localparam logic [ADDR_W-1:0] OFS_DATA_HI = 3'h2;
   localparam logic [ADDR_W-1:0] OFS_BAUD = 3'h3;
   localparam logic [ADDR_W-1:0] OFS_EVENT_EN = 3'h4;
   localparam logic [REG_W-1:0] REG_RESET = 16'h0000;

   // -----------------------------------------------------------------
   // Queue geometry and fields
   // -----------------------------------------------------------------
   localparam int unsigned DATA_W = 32;
   localparam int unsigned HALF_W = 16;
   localparam int unsigned QUEUE_DEPTH = 8;
   localparam int unsigned PTR_W = $clog2(QUEUE_DEPTH);
   localparam int unsigned CNT_W = 6;
   localparam logic [CNT_W-1:0] CNT_FULL = 6'h08;
   localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
   localparam int unsigned RX_CNT_LSB = 8;
   localparam int unsigned TX_CNT_LSB = 0;
   localparam int unsigned DEPTH_BIT3 = 8;
   localparam int unsigned DEPTH_BIT4 = 16;
   localparam int unsigned DEPTH_BIT5 = 32;
   localparam logic [CNT_W-1:0] CNT_BASE_MASK = 6'h07;
   localparam logic [CNT_W-1:0] CNT_BIT3 = 6'h08;
   localparam logic [CNT_W-1:0] CNT_BIT4 = 6'h10;
   localparam logic [CNT_W-1:0] CNT_BIT5 = 6'h20;

   // -----------------------------------------------------------------
   // Divisor and event enables
   // -----------------------------------------------------------------
   localparam int unsigned BAUD_W = 13;
   localparam int unsigned EV_FRAME_ERR = 12;
   localparam int unsigned EV_ACTIVITY = 11;
   localparam int unsigned EV_UNDERRUN = 8;
   localparam int unsigned EV_SHIFT_EMPTY = 7;
   localparam int unsigned EV_OVERFLOW = 6;
   localparam int unsigned EV_RX_EMPTY = 5;
   localparam int unsigned EV_TX_EMPTY = 3;
   localparam int unsigned EV_TX_FULL = 1;
   localparam int unsigned EV_RX_FULL = 0;
   localparam logic [REG_W-1:0] EV_IMPL_MASK = 16'h19eb;

   // -----------------------------------------------------------------
   // Word size lanes
   // -----------------------------------------------------------------
   localparam logic [4:0] WL_USE_MODE = 5'h00;
   localparam logic [4:0] WL_MAX8 = 5'h07;
   localparam logic [4:0] WL_MAX16 = 5'h0f;
   localparam logic [4:0] WL_MAX24 = 5'h17;
   localparam logic [1:0] MODE_8 = 2'b00;
   localparam logic [1:0] MODE_16 = 2'b01;
   localparam logic [DATA_W-1:0] MASK_8 = 32'h0000_00ff;
   localparam logic [DATA_W-1:0] MASK_16 = 32'h0000_ffff;
   localparam logic [DATA_W-1:0] MASK_24 = 32'h00ff_ffff;
   localparam logic [DATA_W-1:0] MASK_32 = 32'hffff_ffff;

   typedef enum logic [1:0] {
      LANE_8 = 2'b00,
      LANE_16 = 2'b01,
      LANE_24 = 2'b10,
      LANE_32 = 2'b11
   } lane_e;

   // Size code zero defers to the coarse mode pins
   function automatic lane_e lane_of(input logic [4:0] wl, input logic [1:0] mode);
      lane_e l;
      l = LANE_32;
      if (wl == WL_USE_MODE) begin
         if (mode == MODE_8) l = LANE_8;
         else if (mode == MODE_16) l = LANE_16;
         else l = LANE_32;
      end else if (wl <= WL_MAX8) l = LANE_8;
      else if (wl <= WL_MAX16) l = LANE_16;
      else if (wl <= WL_MAX24) l = LANE_24;
      return l;
   endfunction

   // Bits of the data window in use per lane
   function automatic logic [DATA_W-1:0] lane_mask(input lane_e l);
      logic [DATA_W-1:0] m;
      m = MASK_32;
      case (l)
         LANE_8: m = MASK_8;
         LANE_16: m = MASK_16;
         LANE_24: m = MASK_24;
         LANE_32: m = MASK_32;
         default: m = MASK_32;
      endcase
      return m;
   endfunction

   // Count bits that physically exist for a given depth
   function automatic logic [CNT_W-1:0] count_mask(input int unsigned depth);
      logic [CNT_W-1:0] m;
      m = CNT_BASE_MASK;
      if (depth >= DEPTH_BIT3) m = m | CNT_BIT3;
      if (depth >= DEPTH_BIT4) m = m | CNT_BIT4;
      if (depth == DEPTH_BIT5) m = m | CNT_BIT5;
      return m;
   endfunction

endpackage
